// ===== rtl/lbd_ctrl.sv
// Dimming, string protection and bus register file of the backlight driver.
// Assumes analog comparators outside; the bus clock is a second clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "lbd_defines.svh"
module lbd_ctrl #(
  parameter int unsigned        SHORT_SW_CYCLES = `LBD_SHORT_SW_CYC,
  parameter int unsigned        RAMP_UNIT       = `LBD_RAMP_UNIT_CYC,
  parameter logic [7:0]         CHIP_ID         = 8'hA5  // Arbitrary value
) (
  input  wire logic             REF_CLK,
  input  wire logic             RST_N,
  input  wire logic             SCL,
  input  wire logic             SDA_IN,
  output logic                  SDA_OUT,
  output logic                  SDA_OE,
  input  wire logic             ADDR_SEL_PIN,
  input  wire lbd_pkg::lbd_prot_t PROT_IN,
  output lbd_pkg::lbd_cfg_t     CFG_OUT,
  output logic                  BOOST_EN,
  output logic                  SW_GATE,
  output logic [7:0]            STR_ON,
  output logic [9:0]            LED_LEVEL
);
  import lbd_pkg::*;

  // ==========================================================
  // Bus clock domain: capture one bit per rising edge
  logic       bit_reg;
  logic       tgl_reg;
  always_ff @(posedge SCL or negedge RST_N) begin
    if (!RST_N) begin
      bit_reg <= 1'b0;
      tgl_reg <= 1'b0;
    end else begin
      bit_reg <= SDA_IN;
      tgl_reg <= ~tgl_reg;
    end
  end

  // ==========================================================
  // Synchronisers into the reference domain
  logic [2:0] tgl_sync_reg;
  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic       scl_d_reg, sda_d_reg;
  logic [1:0] a1_sync_reg;
  lbd_prot_t  prot_m_reg, prot_s;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tgl_sync_reg <= 3'h0;
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
      a1_sync_reg  <= 2'h3;
      prot_m_reg   <= '0;
      prot_s       <= '0;
    end else begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], tgl_reg};
      scl_sync_reg <= {scl_sync_reg[0], SCL};
      sda_sync_reg <= {sda_sync_reg[0], SDA_IN};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
      a1_sync_reg  <= {a1_sync_reg[0], ADDR_SEL_PIN};
      prot_m_reg   <= PROT_IN;
      prot_s       <= prot_m_reg;
    end
  end

  wire logic       scl_s     = scl_sync_reg[1];
  wire logic       sda_s     = sda_sync_reg[1];
  wire logic       rx_ev     = tgl_sync_reg[2] ^ tgl_sync_reg[1];
  wire logic       bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire logic       bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire logic       scl_fall  = scl_d_reg & ~scl_s;
  // Floating select pin reads high
  wire logic [6:0] my_addr   = `LBD_SLAVE_BASE | {6'h00, a1_sync_reg[1]};

  // ==========================================================
  // Register file
  logic [15:0] fsce_reg;
  logic [9:0]  boost_reg, ampl_reg;
  logic [10:0] ramp_reg;
  logic [13:0] duty_reg;
  logic [4:0]  phase_reg, flags_reg;
  logic        wr_en_reg;
  logic [7:0]  wr_addr_reg;
  logic [15:0] wr_data_reg;
  logic [7:0]  ptr_reg;

  wire logic [15:0] rd_word =
      (ptr_reg == `LBD_REG_FSCE)  ? fsce_reg :
      (ptr_reg == `LBD_REG_BOOST) ? {6'h00, boost_reg} :
      (ptr_reg == `LBD_REG_AMPL)  ? {6'h00, ampl_reg} :
      (ptr_reg == `LBD_REG_RAMP)  ? {5'h00, ramp_reg} :
      (ptr_reg == `LBD_REG_DUTY)  ? {2'h0, duty_reg} :
      (ptr_reg == `LBD_REG_STAT)  ? {CHIP_ID, 3'h0, flags_reg} :
      (ptr_reg == `LBD_REG_PHASE) ? {11'h000, phase_reg} : 16'h0000;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fsce_reg  <= `LBD_RST_FSCE;
      boost_reg <= `LBD_RST_BOOST;
      ampl_reg  <= `LBD_RST_AMPL;
      ramp_reg  <= `LBD_RST_RAMP;
      duty_reg  <= `LBD_RST_DUTY;
      phase_reg <= `LBD_RST_PHASE;
    end else if (wr_en_reg) begin
      case (wr_addr_reg)
        `LBD_REG_FSCE:  fsce_reg  <= wr_data_reg;
        `LBD_REG_BOOST: boost_reg <= wr_data_reg[9:0];
        `LBD_REG_AMPL:  ampl_reg  <= wr_data_reg[9:0];
        `LBD_REG_RAMP:  ramp_reg  <= wr_data_reg[10:0];
        `LBD_REG_DUTY:  duty_reg  <= wr_data_reg[13:0];
        `LBD_REG_PHASE: phase_reg <= wr_data_reg[4:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Serial protocol engine
  lbd_phase_t  phase_st_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg, hi_reg, tx_reg;
  logic        ack_pend_reg, byte_sel_reg, oe_reg, sda_out_reg;
  wire logic [7:0] rx_byte  = {shift_reg[6:0], bit_reg};
  wire logic       byte_end = rx_ev & (bit_cnt_reg == 4'h7);
  wire logic       ack_ev   = rx_ev & (bit_cnt_reg == 4'h8);
  wire logic       addr_hit = (rx_byte[7:1] == my_addr);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase_st_reg <= PH_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      hi_reg       <= 8'h00;
      tx_reg       <= 8'h00;
      ptr_reg      <= 8'h00;
      ack_pend_reg <= 1'b0;
      byte_sel_reg <= 1'b0;
      wr_en_reg    <= 1'b0;
      wr_addr_reg  <= 8'h00;
      wr_data_reg  <= 16'h0000;
    end else begin
      wr_en_reg <= 1'b0;
      if (bus_start) begin
        phase_st_reg <= PH_ADDR;
        bit_cnt_reg  <= 4'h0;
        ack_pend_reg <= 1'b0;
      end else if (bus_stop) begin
        phase_st_reg <= PH_IDLE;
        ack_pend_reg <= 1'b0;
      end else if (rx_ev && phase_st_reg != PH_IDLE) begin
        bit_cnt_reg <= (bit_cnt_reg == 4'h8) ? 4'h0 : bit_cnt_reg + 4'h1;
        if (bit_cnt_reg < 4'h8)
          shift_reg <= rx_byte;
        if (byte_end) begin
          case (phase_st_reg)
            PH_ADDR: begin
              ack_pend_reg <= addr_hit;
              byte_sel_reg <= 1'b0;
              tx_reg       <= rd_word[15:8];
              if (!addr_hit)
                phase_st_reg <= PH_IDLE;
              else
                phase_st_reg <= rx_byte[0] ? PH_RDATA : PH_REG;
            end
            PH_REG: begin
              ptr_reg      <= rx_byte;
              ack_pend_reg <= 1'b1;
              byte_sel_reg <= 1'b0;
              phase_st_reg <= PH_WDATA;
            end
            PH_WDATA: begin
              ack_pend_reg <= 1'b1;
              byte_sel_reg <= ~byte_sel_reg;
              if (!byte_sel_reg) begin
                hi_reg <= rx_byte;
              end else begin
                // High byte first, one register per pair
                wr_en_reg   <= 1'b1;
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= {hi_reg, rx_byte};
                ptr_reg     <= ptr_reg + 8'h01;
              end
            end
            default: ;
          endcase
        end else if (ack_ev) begin
          if (ack_pend_reg) begin
            ack_pend_reg <= 1'b0;
          end else if (phase_st_reg == PH_RDATA) begin
            if (bit_reg) begin
              phase_st_reg <= PH_IDLE;
            end else if (!byte_sel_reg) begin
              byte_sel_reg <= 1'b1;
              tx_reg       <= rd_word[7:0];
            end else begin
              byte_sel_reg <= 1'b0;
              ptr_reg      <= ptr_reg + 8'h01;
            end
          end
        end
      end
      // Next register's high byte once the pointer has moved
      if (phase_st_reg == PH_RDATA && !byte_sel_reg && bit_cnt_reg == 4'h0)
        tx_reg <= rd_word[15:8];
    end
  end

  // Drive only after a falling edge, so a start or stop is never faked
  wire logic drive_low = (bit_cnt_reg == 4'h8) ? ack_pend_reg :
                         (phase_st_reg == PH_RDATA) & ~tx_reg[3'h7 - bit_cnt_reg[2:0]];
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      oe_reg      <= 1'b0;
      sda_out_reg <= 1'b0;
    end else if (bus_start || bus_stop) begin
      oe_reg <= 1'b0;
    end else if (scl_fall) begin
      oe_reg <= drive_low;
    end
  end
  assign SDA_OE  = oe_reg;
  assign SDA_OUT = sda_out_reg;

  // ==========================================================
  // Switching cycle timing and protection
  lbd_state_t  state_reg;
  logic [6:0]  sw_cnt_reg;
  logic [3:0]  chk_cnt_reg;
  logic [7:0]  active_reg;
  logic        current_limit_bit_blk_reg, oc_seen_reg;
  logic [2:0]  oc_run_reg, pre_cnt_reg;
  logic [7:0]  short_exp;
  wire logic   sw_tick    = (sw_cnt_reg == 7'(`LBD_SW_CYC - 1));
  wire logic [7:0] chen   = fsce_reg[`LBD_F_CHEN];
  wire logic   boost_on   = (state_reg == ST_RUN) & ~prot_s.over_temp & (|active_reg);
  wire logic   current_limit_bit_next  = prot_s.current_limit_bit | (current_limit_bit_blk_reg & ~sw_tick);
  wire logic   boost_ready = (pre_cnt_reg == `LBD_PRE_SW_CYC);
  wire logic   oc_cycle   = oc_seen_reg | prot_s.latch_oc;
  wire logic   oc_latch   = sw_tick & oc_cycle & (oc_run_reg == `LBD_LATCH_SW_CYC - 3'd1);
  wire logic [7:0] open_str = (prot_s.ovp && state_reg == ST_RUN) ? prot_s.str_low : 8'h00;
  wire logic [7:0] keep_str = active_reg & ~short_exp & ~open_str;
  wire logic   all_short  = (|short_exp) & (keep_str == 8'h00);

  // One short timer per string, counted in switching cycles
  generate
    for (genvar gi = 0; gi < 8; gi++) begin : g_short
      logic [13:0] cnt_reg;
      wire logic   hot = active_reg[gi] & prot_s.str_short[gi] & (state_reg == ST_RUN);
      assign short_exp[gi] = hot & sw_tick & (cnt_reg == 14'(SHORT_SW_CYCLES - 1));
      always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N)
          cnt_reg <= 14'h0000;
        else if (!hot)
          cnt_reg <= 14'h0000;
        else if (sw_tick)
          cnt_reg <= cnt_reg + 14'h0001;
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg    <= ST_CHECK;
      sw_cnt_reg   <= 7'h00;
      chk_cnt_reg  <= 4'h0;
      active_reg   <= 8'h00;
      current_limit_bit_blk_reg <= 1'b0;
      oc_seen_reg  <= 1'b0;
      oc_run_reg   <= 3'h0;
      pre_cnt_reg  <= 3'h0;
      flags_reg    <= 5'h00;
    end else begin
      sw_cnt_reg   <= sw_tick ? 7'h00 : sw_cnt_reg + 7'h01;
      current_limit_bit_blk_reg <= current_limit_bit_next;
      oc_seen_reg  <= sw_tick ? 1'b0 : oc_cycle;
      if (sw_tick)
        oc_run_reg <= oc_cycle ? oc_run_reg + 3'h1 : 3'h0;
      if (!boost_on)
        pre_cnt_reg <= 3'h0;
      else if (sw_tick && !boost_ready)
        pre_cnt_reg <= pre_cnt_reg + 3'h1;
      // Flags only ever set; they clear with the restart
      flags_reg <= flags_reg | {prot_s.over_temp, oc_latch,
                                prot_s.ovp & (state_reg == ST_RUN),
                                |open_str, |short_exp};
      case (state_reg)
        ST_CHECK: begin
          chk_cnt_reg <= chk_cnt_reg + 4'h1;
          if (chk_cnt_reg == `LBD_CHECK_CYC) begin
            active_reg <= chen & ~prot_s.str_low;
            state_reg  <= ST_RUN;
          end
        end
        ST_RUN: begin
          active_reg <= keep_str;
          if (all_short || oc_latch)
            state_reg <= ST_OFF;
        end
        ST_OFF:  state_reg <= ST_OFF;
        default: state_reg <= ST_CHECK;
      endcase
    end
  end

  // ==========================================================
  // Phase-shifted dimming
  function automatic logic [14:0] step_of(input logic [3:0] n);
    case (n)
      4'd2:    step_of = 15'd8192;
      4'd3:    step_of = 15'd5461;
      4'd4:    step_of = 15'd4096;
      4'd5:    step_of = 15'd3277;
      4'd6:    step_of = 15'd2731;
      4'd7:    step_of = 15'd2341;
      4'd8:    step_of = 15'd2048;
      default: step_of = 15'd0;
    endcase
  endfunction

  logic [13:0] dim_cnt_reg;
  logic [3:0]  n_used;
  always_comb begin
    n_used = 4'h0;
    for (int k = 0; k < 8; k++)
      n_used = n_used + {3'h0, chen[k]};
  end
  wire logic [1:0]  ps       = phase_reg[`LBD_F_PS];
  wire logic [2:0]  mode     = boost_reg[`LBD_F_MODE];
  wire logic        pwm_mode = mode[1] | mode[2];
  wire logic [3:0]  n_pairs  = (n_used + 4'h1) >> 1;
  wire logic [14:0] step_ch  = step_of(n_used);
  wire logic [14:0] step_pr  = step_of(n_pairs);
  logic [7:0] ch_on;
  generate
    for (genvar gc = 0; gc < 8; gc++) begin : g_phase
      wire logic [2:0]  pair_lag = 3'(n_pairs - 4'h1 - 4'(gc / 2));
      wire logic [17:0] off_ch   = 18'(gc) * 18'(step_ch);
      wire logic [17:0] off_pr   = 18'(pair_lag) * 18'(step_pr);
      wire logic [13:0] offset   = (ps == 2'b00) ? off_ch[13:0] :
                                   (ps == 2'b10) ? off_pr[13:0] :
                                   (ps == 2'b11 && gc < 4) ? `LBD_PHASE_90 : 14'h0000;
      wire logic [13:0] pos      = dim_cnt_reg - offset;
      assign ch_on[gc] = ~pwm_mode | (pos < duty_reg);
    end
  endgenerate

  // ==========================================================
  // Linear fade and registered outputs
  logic [13:0] ramp_cnt_reg;
  wire logic [2:0]  tslp     = (ramp_reg[`LBD_F_TSLP] == 3'h7) ? 3'h6 : ramp_reg[`LBD_F_TSLP];
  wire logic [13:0] ramp_lim = 14'(RAMP_UNIT << tslp) - 14'h0001;
  wire logic        ramp_tick = (ramp_cnt_reg >= ramp_lim);
  wire logic [7:0]  on_next  = boost_ready ? (active_reg & ch_on) : 8'h00;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dim_cnt_reg  <= 14'h0000;
      ramp_cnt_reg <= 14'h0000;
      LED_LEVEL    <= 10'h000;
      STR_ON       <= 8'h00;
      BOOST_EN     <= 1'b0;
      SW_GATE      <= 1'b0;
      CFG_OUT      <= '0;
    end else begin
      dim_cnt_reg  <= dim_cnt_reg + 14'h0001;
      ramp_cnt_reg <= ramp_tick ? 14'h0000 : ramp_cnt_reg + 14'h0001;
      if (ramp_tick && LED_LEVEL < ampl_reg)
        LED_LEVEL <= LED_LEVEL + 10'h001;
      else if (ramp_tick && LED_LEVEL > ampl_reg)
        LED_LEVEL <= LED_LEVEL - 10'h001;
      STR_ON   <= on_next;
      BOOST_EN <= boost_on;
      // Open string pulls its pin low; boost keeps rising until the trip
      SW_GATE  <= boost_on & ~prot_s.ovp & ~current_limit_bit_next;
      CFG_OUT  <= '{full_scale: fsce_reg[`LBD_F_ISET], ovp_sel: boost_reg[`LBD_F_OVP],
                    short_sel: ramp_reg[`LBD_F_SHORT], current_limit_bit_sel: boost_reg[`LBD_F_CURRENT_LIMIT_BIT],
                    sync_en: boost_reg[`LBD_F_SYNC]};
    end
  end

  // ==========================================================
  // Assertions
  property p_ovp_stop;
    @(posedge REF_CLK) disable iff (!RST_N) prot_s.ovp |=> !SW_GATE;
  endproperty
  a_ovp_stop: assert property (p_ovp_stop) else $error("switching during over-voltage");
  property p_current_limit_bit_cycle;
    @(posedge REF_CLK) disable iff (!RST_N) (prot_s.current_limit_bit && !sw_tick) |=> !SW_GATE;
  endproperty
  a_current_limit_bit_cycle: assert property (p_current_limit_bit_cycle) else $error("switch ran past current limit");
  property p_otp_off;
    @(posedge REF_CLK) disable iff (!RST_N) prot_s.over_temp |=> (!BOOST_EN && flags_reg[4]);
  endproperty
  a_otp_off: assert property (p_otp_off) else $error("boost on while over temperature");
  property p_short_sticky;
    @(posedge REF_CLK) disable iff (!RST_N)
      (state_reg != ST_CHECK) |=> ((active_reg & ~$past(active_reg)) == 8'h00);
  endproperty
  a_short_sticky: assert property (p_short_sticky) else $error("removed string came back");
  property p_off_latched;
    @(posedge REF_CLK) disable iff (!RST_N) (state_reg == ST_OFF) |=> ##[0:1] !BOOST_EN [*4];
  endproperty
  a_off_latched: assert property (p_off_latched) else $error("boost left latched off");
  property p_pre_cycles;
    @(posedge REF_CLK) disable iff (!RST_N) $rose(|STR_ON) |-> $past(pre_cnt_reg) == 3'd4;
  endproperty
  a_pre_cycles: assert property (p_pre_cycles) else $error("LED pulse before four cycles");
  property p_addr_miss;
    @(posedge REF_CLK) disable iff (!RST_N)
      (byte_end && phase_st_reg == PH_ADDR && !addr_hit) |=> (!ack_pend_reg && phase_st_reg == PH_IDLE);
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("answered foreign address");
  property p_write_word;
    @(posedge REF_CLK) disable iff (!RST_N)
      (wr_en_reg && wr_addr_reg == 8'h04) |=> (duty_reg == $past(wr_data_reg[13:0]));
  endproperty
  a_write_word: assert property (p_write_word) else $error("word write lost");
  property p_ramp_step;
    @(posedge REF_CLK) disable iff (!RST_N) (LED_LEVEL != $past(LED_LEVEL)) |-> $past(ramp_tick);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("level moved off a ramp tick");
  cv_read:  cover property (@(posedge REF_CLK) disable iff (!RST_N) ack_ev && phase_st_reg == PH_RDATA);
  cv_write: cover property (@(posedge REF_CLK) disable iff (!RST_N) wr_en_reg);
  cv_short: cover property (@(posedge REF_CLK) disable iff (!RST_N) |short_exp);
  cv_off:   cover property (@(posedge REF_CLK) disable iff (!RST_N) state_reg == ST_OFF);
endmodule
`default_nettype wire

// ===== rtl/lbd_defines.svh
// Constants of the LED backlight dimming and protection controller.
// Assumes a 100 MHz reference clock and 1.2 MHz boost switching.
`ifndef LBD_DEFINES_SVH
`define LBD_DEFINES_SVH

// ==========================================================
// Register offsets and reset values
`define LBD_REG_FSCE   8'h00
`define LBD_REG_BOOST  8'h01
`define LBD_REG_AMPL   8'h02
`define LBD_REG_RAMP   8'h03
`define LBD_REG_DUTY   8'h04
`define LBD_REG_STAT   8'h05
`define LBD_REG_PHASE  8'h06
`define LBD_RST_FSCE   16'h623F
`define LBD_RST_BOOST  10'h280
`define LBD_RST_AMPL   10'h3FF
`define LBD_RST_RAMP   11'h000
`define LBD_RST_DUTY   14'h3FFF
`define LBD_RST_PHASE  5'h00

// ==========================================================
// Field positions
`define LBD_F_ISET   15:8
`define LBD_F_CHEN   7:0
`define LBD_F_OVP    9:8
`define LBD_F_SYNC   7
`define LBD_F_MODE   6:4
`define LBD_F_CURRENT_LIMIT_BIT   3
`define LBD_F_TSLP   10:8
`define LBD_F_SHORT  7:6
`define LBD_F_PS     1:0

// ==========================================================
// Bus address and timing
`define LBD_SLAVE_BASE    7'h28
`define LBD_REF_FREQ_KHZ  100000
`define LBD_SW_FREQ_KHZ   1200
`define LBD_SW_CYC        (`LBD_REF_FREQ_KHZ / `LBD_SW_FREQ_KHZ)
`define LBD_RAMP_UNIT_NS  2000
`define LBD_RAMP_UNIT_CYC ((`LBD_RAMP_UNIT_NS * `LBD_REF_FREQ_KHZ + 999999) / 1000000)
`define LBD_SHORT_US      6900
`define LBD_SHORT_SW_CYC  (`LBD_SHORT_US * `LBD_SW_FREQ_KHZ / 1000)
`define LBD_PRE_SW_CYC    3'd4
`define LBD_LATCH_SW_CYC  3'd5
`define LBD_CHECK_CYC     4'hF
`define LBD_PHASE_90      14'h1000

`endif

// ===== rtl/lbd_pkg.sv
// Types shared by the LED backlight controller.
// Assumes lbd_defines.svh for all numeric constants.
package lbd_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_REG, PH_WDATA, PH_RDATA} lbd_phase_t;
  typedef enum logic [1:0] {ST_CHECK, ST_RUN, ST_OFF} lbd_state_t;
  typedef struct packed {
    logic       over_temp;
    logic       latch_oc;
    logic       current_limit_bit;
    logic       ovp;
    logic [7:0] str_short;
    logic [7:0] str_low;
  } lbd_prot_t;
  typedef struct packed {
    logic [7:0] full_scale;
    logic [1:0] ovp_sel;
    logic [1:0] short_sel;
    logic       current_limit_bit_sel;
    logic       sync_en;
  } lbd_cfg_t;
endpackage

// ===== sim/lbd_ctrl_tb_top.sv
// Self-checking bench of the backlight controller.
// Assumes the master model makes SCL; PROT_IN is driven here.
`timescale 1ns/10ps
`default_nettype none
module lbd_ctrl_tb_top;
  import lbd_pkg::*;
  localparam logic [7:0]  ID = 8'h3C;  // Arbitrary value
  localparam logic [15:0] RST [8] = '{16'h623F, 16'h0280, 16'h03FF, 16'h0000,
                                     16'h3FFF, {ID, 8'h00}, 16'h0000, 16'h0000};
  logic       clk = 1'b0, rst_n = 1'b0, sel = 1'b0, a, sda_oe, sda_o, scl, pull, boost, gate;
  lbd_prot_t  prot = '0;
  lbd_cfg_t   cfg;
  logic [7:0] str_on, junk;
  logic [9:0] level;
  logic [15:0] v, w;
  wire logic  sda = ~(pull | sda_oe);
  int         n_errors = 0, check_count = 0, seed = 32'hE508;
  lbd_ctrl #(.SHORT_SW_CYCLES(20), .RAMP_UNIT(4), .CHIP_ID(ID)) dut (
    .REF_CLK(clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE(sda_oe),
    .ADDR_SEL_PIN(sel), .PROT_IN(prot), .CFG_OUT(cfg), .BOOST_EN(boost), .SW_GATE(gate),
    .STR_ON(str_on), .LED_LEVEL(level));
  lbd_i2c_master m (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] mask(input int r);
    case (r)
      0: mask = 16'hFFFF;
      1, 2: mask = 16'h03FF;
      3: mask = 16'h07FF;
      4: mask = 16'h3FFF;
      6: mask = 16'h001F;
      default: mask = 16'h0000;
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic results();
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input int r, input logic [15:0] d);
    m.start();
    m.xfer({6'h14, sel, 1'b0}, 1'b0, junk, a);
    m.xfer(r[7:0], 1'b0, junk, a);
    m.xfer(d[15:8], 1'b0, junk, a);
    m.xfer(d[7:0], 1'b0, junk, a);
    m.stop();
  endtask
  task automatic rd(input int r, output logic [15:0] q);
    m.start();
    m.xfer({6'h14, sel, 1'b0}, 1'b0, junk, a);
    m.xfer(r[7:0], 1'b0, junk, a);
    m.start();
    m.xfer({6'h14, sel, 1'b1}, 1'b0, junk, a);
    m.xfer(8'hFF, 1'b1, q[15:8], a);
    m.xfer(8'hFF, 1'b0, q[7:0], a);
    m.stop();
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      sel <= s[0];
      // Short settle; the full enable wait would outlast the run
      repeat (4) @(posedge clk);
      for (int d = 0; d < 2; d++) begin
        m.start();
        m.xfer({6'h14, d[0], 1'b0}, 1'b0, junk, a);
        m.stop();
        chk({15'h0, a}, {15'h0, s == d});
      end
    end
    for (int r = 0; r < 8; r++) begin
      rd(r, v);
      chk(v, RST[r]);
    end
    for (int r = 0; r < 8; r++) begin
      w = $random(seed);
      wr(r, w);
      rd(r, v);
      chk(v, (r == 5) ? RST[5] : (w & mask(r)));
      if (r == 1) begin
        chk({12'h0, cfg.ovp_sel, cfg.sync_en, cfg.current_limit_bit_sel}, {12'h0, w[9:7], w[3]});
      end
    end
    wr(0, 16'h623F);
    wr(1, 16'h0280);
    wr(2, 16'h0155);
    wr(3, 16'h0000);
    repeat (5000) @(posedge clk);
    chk({6'h0, level}, 16'h0155);
    chk({15'h0, boost}, 16'h0001);
    // Current limit drops the gate, over-temperature drops the boost
    for (int k = 0; k < 2; k++) begin
      prot[17 + 2 * k] <= 1'b1;
      repeat (6) @(posedge clk);
      chk({15'h0, k ? boost : gate}, 16'h0000);
      prot[17 + 2 * k] <= 1'b0;
      repeat (200) @(posedge clk);
      chk({15'h0, k ? boost : gate}, 16'h0001);
    end
    prot.str_low[1] <= 1'b1;
    prot.ovp <= 1'b1;
    prot.str_short[0] <= 1'b1;
    repeat (2490) @(posedge clk);
    prot.ovp <= 1'b0;
    prot.str_short[0] <= 1'b0;
    repeat (200) @(posedge clk);
    chk({8'h0, str_on}, 16'h003C);
    // Register PWM mode at zero duty: no pulse shorter than the advised on-time
    wr(4, 16'h0000);
    wr(1, 16'h02B0);
    repeat (20) @(posedge clk);
    chk({8'h0, str_on}, 16'h0000);
    prot.latch_oc <= 1'b1;
    repeat (581) @(posedge clk);
    prot.latch_oc <= 1'b0;
    repeat (200) @(posedge clk);
    chk({15'h0, boost}, 16'h0000);
    rd(5, v);
    chk(v, {ID, 8'h1F});
    // Restart releases the latch-off and clears the sticky flags
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (200) @(posedge clk);
    chk({15'h0, boost}, 16'h0001);
    rd(5, v);
    chk(v, RST[5]);
    results();
  end
endmodule
`default_nettype wire

// ===== sim/lbd_i2c_master.sv
// Bus master model for the backlight controller.
// Assumes the bench resolves SDA with a pull-up; SCL stands high between frames.
`timescale 1ns/10ps
`default_nettype none
module lbd_i2c_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic step(input int n, input logic c, input logic p);
    repeat (n) @(posedge clk);
    scl <= c;
    sda_pull <= p;
  endtask
  task automatic start();
    step(8, 1'b0, 1'b0);
    step(8, 1'b1, 1'b0);
    step(8, 1'b1, 1'b1);
    step(8, 1'b0, 1'b1);
  endtask
  task automatic stop();
    step(8, 1'b0, 1'b1);
    step(8, 1'b1, 1'b1);
    step(8, 1'b1, 1'b0);
  endtask
  // Data moves 2 cycles after SCL falls, clear of the device's hold window
  task automatic bitx(input logic b, output logic r);
    step(2, 1'b0, ~b);
    step(6, 1'b1, ~b);
    repeat (8) @(posedge clk);
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(~mack, x);
    ack = ~x;
  endtask
endmodule
`default_nettype wire
